// ### caf_cfg.svh
// Notes on behaviour
// - filter bits 15..5 hold the 11-bit standard id compared with received id.
// - a standard id filter bit of one needs the received bit one.
// - a standard id filter bit of zero needs the received bit zero.
// - type enable set and frame select one: accept extended frames only.
// - type enable set and frame select zero: accept standard frames only.
// - type enable clear: frame select ignored, both frame types may match.
// - bits 1..0 hold extended id bits 17..16; on extended frames one needs received one.
// - register bits 4 and 2 ignore writes and read as zero.
`ifndef CAF_CFG_SVH
`define CAF_CFG_SVH

// ****************************************
// register map
// ****************************************
`define CAF_ADDR_FILT     12'h000
`define CAF_ADDR_CTRL     12'h004
`define CAF_ADDR_STAT     12'h008

// ****************************************
// field layout
// ****************************************
`define CAF_STD_ID_HI     15
`define CAF_STD_ID_LO     5
`define CAF_FSEL_BIT      3
`define CAF_EXT_ID_HI     1
`define CAF_EXT_ID_LO     0
`define CAF_FILT_WMASK    16'hFFEB
`define CAF_CTRL_TYPE_EN_BIT 0
`define CAF_STAT_HIT_BIT  0
`define CAF_STAT_CNT_LO   8
`define CAF_STAT_CNT_HI   15

// ****************************************
// reset values and other constants
// ****************************************
`define CAF_ZERO_WORD     32'h0000_0000
`define CAF_CNT_RST       8'h00
`define CAF_CNT_ONE       8'h01
`define CAF_EXT_ID_PAD    9'h000

`endif

// ### caf_pkg.sv
package caf_pkg;

  typedef logic [10:0] caf_std_id_t;
  typedef logic [1:0]  caf_ext_id_t;
  typedef logic [15:0] caf_reg_t;

  // exact compare of one identifier field, narrower fields zero padded
  function automatic logic caf_field_eq(input caf_std_id_t filt,
                                        input caf_std_id_t rx);
    return (filt == rx);
  endfunction : caf_field_eq

endpackage : caf_pkg

// ### caf_cmp_if.sv
`timescale 1ns/10ps
`default_nettype none
interface caf_cmp_if;
  import caf_pkg::*;

  caf_std_id_t filt_std_id;
  caf_ext_id_t filt_ext_id;
  logic        frame_sel;
  logic        type_en;
  logic        rx_valid;
  logic        rx_ext;
  caf_std_id_t rx_std_id;
  caf_ext_id_t rx_ext_id;
  logic        hit;
  logic        valid;

  modport ctl (output filt_std_id, filt_ext_id, frame_sel, type_en,
               output rx_valid, rx_ext, rx_std_id, rx_ext_id,
               input  hit, valid);
  modport cmp (input  filt_std_id, filt_ext_id, frame_sel, type_en,
               input  rx_valid, rx_ext, rx_std_id, rx_ext_id,
               output hit, valid);
endinterface : caf_cmp_if
`default_nettype wire

// ### caf_cmp.sv
`timescale 1ns/10ps
`default_nettype none
`include "caf_cfg.svh"
module caf_cmp
  import caf_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // compare channel
  caf_cmp_if.cmp    cb
);

  logic     std_ok;
  logic     ext_ok;
  logic     type_ok;
  logic     hit_ff;
  logic     valid_ff;

  // ****************************************
  // identifier compare
  // ****************************************
  // every filter bit must equal its received bit, ones and zeros alike
  assign std_ok = caf_field_eq(cb.filt_std_id,
                               cb.rx_std_id);
  // standard frames carry no extended bits, so those only count when extended
  assign ext_ok = !cb.rx_ext ||
                  caf_field_eq({`CAF_EXT_ID_PAD, cb.filt_ext_id},
                               {`CAF_EXT_ID_PAD, cb.rx_ext_id});
  // frame type only checked while the type enable is set
  assign type_ok = !cb.type_en ||
                   (cb.frame_sel == cb.rx_ext);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      valid_ff <= 1'b0;
    else
      valid_ff <= cb.rx_valid;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      hit_ff <= 1'b0;
    else if (cb.rx_valid)
      hit_ff <= std_ok && ext_ok && type_ok;
  end

  assign cb.hit   = hit_ff;
  assign cb.valid = valid_ff;

  // ****************************************
  // checks
  // ****************************************
  property p_full_match;
    @(posedge clk) disable iff (!resetn)
    cb.rx_valid && (cb.filt_std_id == cb.rx_std_id) &&
    (!cb.rx_ext || (cb.filt_ext_id == cb.rx_ext_id)) &&
    (!cb.type_en || (cb.frame_sel == cb.rx_ext))
    |=> cb.valid && cb.hit;
  endproperty
  a_full_match: assert property (p_full_match)
    else $error("matching id was not accepted");

  property p_std_one;
    @(posedge clk) disable iff (!resetn)
    cb.rx_valid && |(cb.filt_std_id & ~cb.rx_std_id) |=> !cb.hit;
  endproperty
  a_std_one: assert property (p_std_one)
    else $error("filter one against received zero matched");

  property p_std_zero;
    @(posedge clk) disable iff (!resetn)
    cb.rx_valid && |(~cb.filt_std_id & cb.rx_std_id) |=> !cb.hit;
  endproperty
  a_std_zero: assert property (p_std_zero)
    else $error("filter zero against received one matched");

  property p_ext_only;
    @(posedge clk) disable iff (!resetn)
    cb.rx_valid && cb.type_en && cb.frame_sel && !cb.rx_ext |=> !cb.hit;
  endproperty
  a_ext_only: assert property (p_ext_only)
    else $error("standard frame passed an extended-only filter");

  property p_std_only;
    @(posedge clk) disable iff (!resetn)
    cb.rx_valid && cb.type_en && !cb.frame_sel && cb.rx_ext |=> !cb.hit;
  endproperty
  a_std_only: assert property (p_std_only)
    else $error("extended frame passed a standard-only filter");

  property p_type_ignored;
    @(posedge clk) disable iff (!resetn)
    cb.rx_valid && !cb.type_en && (cb.filt_std_id == cb.rx_std_id) &&
    (!cb.rx_ext || (cb.filt_ext_id == cb.rx_ext_id)) ##1 cb.valid
    |-> cb.hit;
  endproperty
  a_type_ignored: assert property (p_type_ignored)
    else $error("frame select was not ignored");

  property p_ext_one;
    @(posedge clk) disable iff (!resetn)
    cb.rx_valid && cb.rx_ext && |(cb.filt_ext_id & ~cb.rx_ext_id)
    |=> !cb.hit;
  endproperty
  a_ext_one: assert property (p_ext_one)
    else $error("extended filter one against received zero matched");

  property p_ext_zero;
    @(posedge clk) disable iff (!resetn)
    cb.rx_valid && cb.rx_ext && |(~cb.filt_ext_id & cb.rx_ext_id)
    |=> !cb.hit;
  endproperty
  a_ext_zero: assert property (p_ext_zero)
    else $error("extended filter zero against received one matched");

endmodule : caf_cmp
`default_nettype wire

// ### caf_top.sv
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "caf_cfg.svh"
module caf_top
  import caf_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // received message identifier
  input  wire logic        rx_valid,
  input  wire logic        rx_ext,
  input  wire logic [10:0] rx_std_id,
  input  wire logic [1:0]  rx_ext_id_hi,
  // acceptance result
  output logic             accept_valid,
  output logic             accept_hit
);

  caf_cmp_if   cmp_bus ();

  caf_reg_t    filt_ff;
  logic        type_en_ff;
  logic [7:0]  hit_cnt_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        setup;
  logic        wr_done;
  logic        addr_ok;
  caf_reg_t    nxt_filt;
  logic [31:0] rd_word;

  // ****************************************
  // apb handshake
  // ****************************************
  // one wait-free access cycle; pready is registered so the answer comes
  // from a flop, at the cost of answering only in the first access cycle
  assign setup   = psel && !penable;
  assign wr_done = psel && penable && pready_ff && pwrite;
  assign addr_ok = (paddr == `CAF_ADDR_FILT) ||
                   (paddr == `CAF_ADDR_CTRL) ||
                   (paddr == `CAF_ADDR_STAT);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pready_ff <= 1'b0;
    else
      pready_ff <= setup;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pslverr_ff <= 1'b0;
    else
      pslverr_ff <= setup && !addr_ok;
  end

  // ****************************************
  // filter identifier register
  // ****************************************
  always_comb
  begin
    nxt_filt = filt_ff;
    if (pstrb[0])
      nxt_filt[7:0] = pwdata[7:0];
    if (pstrb[1])
      nxt_filt[15:8] = pwdata[15:8];
    nxt_filt = nxt_filt & `CAF_FILT_WMASK;
  end

  // contents are undefined until software writes them, so no reset here
  always_ff @(posedge clk)
  begin
    if (wr_done && (paddr == `CAF_ADDR_FILT))
      filt_ff <= nxt_filt;
  end

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      type_en_ff <= 1'b0;
    else if (wr_done && (paddr == `CAF_ADDR_CTRL) && pstrb[0])
      type_en_ff <= pwdata[`CAF_CTRL_TYPE_EN_BIT];
  end

  // ****************************************
  // status: accepted message count
  // ****************************************
  // the count wraps; software samples it before and after a burst
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      hit_cnt_ff <= `CAF_CNT_RST;
    else if (cmp_bus.valid && cmp_bus.hit)
      hit_cnt_ff <= hit_cnt_ff + `CAF_CNT_ONE;
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb
  begin
    rd_word = `CAF_ZERO_WORD;
    case (paddr)
      `CAF_ADDR_FILT:
        rd_word[15:0] = filt_ff & `CAF_FILT_WMASK;
      `CAF_ADDR_CTRL:
        rd_word[`CAF_CTRL_TYPE_EN_BIT] = type_en_ff;
      `CAF_ADDR_STAT:
      begin
        rd_word[`CAF_STAT_HIT_BIT] = cmp_bus.hit;
        rd_word[`CAF_STAT_CNT_HI:`CAF_STAT_CNT_LO] = hit_cnt_ff;
      end
      default:
        rd_word = `CAF_ZERO_WORD;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      prdata_ff <= `CAF_ZERO_WORD;
    else if (setup && !pwrite)
      prdata_ff <= rd_word;
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // ****************************************
  // compare engine
  // ****************************************
  assign cmp_bus.filt_std_id = filt_ff[`CAF_STD_ID_HI:`CAF_STD_ID_LO];
  assign cmp_bus.filt_ext_id = filt_ff[`CAF_EXT_ID_HI:`CAF_EXT_ID_LO];
  assign cmp_bus.frame_sel   = filt_ff[`CAF_FSEL_BIT];
  assign cmp_bus.type_en     = type_en_ff;
  assign cmp_bus.rx_valid    = rx_valid;
  assign cmp_bus.rx_ext      = rx_ext;
  assign cmp_bus.rx_std_id   = rx_std_id;
  assign cmp_bus.rx_ext_id   = rx_ext_id_hi;

  caf_cmp u_cmp (
    .clk    (clk),
    .resetn (resetn),
    .cb     (cmp_bus)
  );

  assign accept_valid = cmp_bus.valid;
  assign accept_hit   = cmp_bus.hit;

  // ****************************************
  // checks
  // ****************************************
  property p_unimpl_zero;
    @(posedge clk) disable iff (!resetn)
    setup && !pwrite && (paddr == `CAF_ADDR_FILT)
    |=> pready && !prdata[4] && !prdata[2];
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented filter bit read as one");

  property p_filt_write;
    logic [15:0] d;
    @(posedge clk) disable iff (!resetn)
    (wr_done && (paddr == `CAF_ADDR_FILT) && (&pstrb[1:0]), d = pwdata[15:0])
    |=> (filt_ff == (d & `CAF_FILT_WMASK));
  endproperty
  a_filt_write: assert property (p_filt_write)
    else $error("filter write not stored as masked data");

  property p_one_wait;
    @(posedge clk) disable iff (!resetn)
    setup |=> pready ##1 !pready;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("apb answer not one cycle after setup");

endmodule : caf_top
`default_nettype wire

// ### caf_rx_src.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// received message source
// ****************************************
module caf_rx_src
  import caf_pkg::*;
(
  // clock and reset
  input  wire logic     clk,
  input  wire logic     resetn,
  // bench request, one message per cycle while go is high
  input  wire logic        go,
  input  wire logic        ext,
  input  wire caf_std_id_t std_id,
  input  wire caf_ext_id_t ext_id,
  // received id toward the filter
  output logic             rx_valid,
  output logic             rx_ext,
  output var caf_std_id_t  rx_std_id,
  output var caf_ext_id_t  rx_ext_id_hi
);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_valid  <= 1'b0;
      rx_ext    <= 1'b0;
      rx_std_id    <= 11'h000;
      rx_ext_id_hi <= 2'h0;
    end
    else if (go)
    begin
      rx_valid  <= 1'b1;
      rx_ext    <= ext;
      rx_std_id    <= std_id;
      rx_ext_id_hi <= ext_id;
    end
    else
    begin
      // id lines mean nothing between messages, so keep them moving
      rx_valid  <= 1'b0;
      rx_ext    <= ~rx_ext;
      rx_std_id    <= ~rx_std_id;
      rx_ext_id_hi <= ~rx_ext_id_hi;
    end
  end
endmodule : caf_rx_src
`default_nettype wire

// ### test_can_acceptance_filter_id_match.sv
`timescale 1ns/10ps
`default_nettype none
`include "caf_cfg.svh"
module test_can_acceptance_filter_id_match;
  import caf_pkg::*;
  typedef struct packed {logic [31:0] d; logic e; logic rd;} caf_apb_s;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready, pslverr, accept_valid, accept_hit;
  logic        rx_valid, rx_ext;
  caf_std_id_t rx_std_id;
  caf_ext_id_t rx_ext_id_hi;
  logic        go = 1'b0;
  logic        m_ext = 1'b0;
  caf_std_id_t m_std_id = 11'h000;
  caf_ext_id_t m_ext_id = 2'h0;
  caf_std_id_t f_std_id;
  caf_ext_id_t f_ext_id;
  logic        f_sel, type_en, last_hit;
  int          n_acc = 0;
  int          mismatches = 0;
  int          tests_run = 0;
  logic [31:0] seed = 32'h6B37;
  caf_apb_s    apb_q[$];
  logic        hit_q[$];

  always #10 clk = ~clk;

  caf_top dut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_ext(rx_ext), .rx_std_id(rx_std_id),
    .rx_ext_id_hi(rx_ext_id_hi), .accept_valid(accept_valid),
    .accept_hit(accept_hit));
  caf_rx_src u_src (.clk(clk), .resetn(resetn), .go(go), .ext(m_ext),
    .std_id(m_std_id), .ext_id(m_ext_id), .rx_valid(rx_valid),
    .rx_ext(rx_ext), .rx_std_id(rx_std_id),
    .rx_ext_id_hi(rx_ext_id_hi));

  // ****************************************
  // stimulus helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // waits on pready with no fixed count; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] ex,
                     input logic er);
    caf_apb_s s;
    s = '{d: ex, e: er, rd: !w};
    apb_q.push_back(s);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic send(input logic e, input caf_std_id_t s,
                      input caf_ext_id_t x);
    logic h;
    h = (s == f_std_id) && (!e || x == f_ext_id) &&
        (!type_en || f_sel == e);
    hit_q.push_back(h);
    n_acc    = n_acc + int'(h);
    last_hit = h;
    @(posedge clk);
    go    <= 1'b1;
    m_ext <= e;
    m_std_id <= s;
    m_ext_id <= x;
  endtask : send

  task automatic wrap_up();
    if (hit_q.size() != 0)
      mismatches++;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // ****************************************
  // result monitors
  // ****************************************
  always @(posedge clk)
  begin : mon_apb
    caf_apb_s s;
    if (resetn && psel && penable && pready === 1'b1)
    begin
      s = apb_q.pop_front();
      tests_run++;
      if ({s.rd ? prdata : s.d, pslverr} !== {s.d, s.e})
      begin
        mismatches++;
        $display("CHECK FAILED apb %h exp %h/%b got %h/%b", paddr, s.d, s.e,
                 prdata, pslverr);
      end
    end
  end

  always @(posedge clk)
  begin : mon_rx
    logic h;
    if (accept_valid === 1'b1)
    begin
      h = hit_q.pop_front();
      tests_run++;
      if (accept_hit !== h)
      begin
        mismatches++;
        $display("CHECK FAILED accept_hit exp %b got %b", h, accept_hit);
      end
    end
  end

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin : main
    logic [31:0] r;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b1, `CAF_ADDR_FILT, 32'hFFFF_FFFF, 32'h0, 1'b0);
    apb(1'b0, `CAF_ADDR_FILT, 32'h0, 32'h0000_FFEB, 1'b0);
    apb(1'b0, 12'h0FC, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF, 32'h0, 1'b1);
    repeat (40)
    begin
      r     = xs();
      f_std_id = r[10:0];
      f_ext_id = r[12:11];
      f_sel    = r[13];
      type_en  = r[14];
      // bits 4 and 2 written as one must still read back as zero
      apb(1'b1, `CAF_ADDR_FILT,
          {16'h0, f_std_id, 1'b1, f_sel, 1'b1, f_ext_id},
          32'h0, 1'b0);
      apb(1'b1, `CAF_ADDR_CTRL, {31'h0, type_en}, 32'h0, 1'b0);
      apb(1'b0, `CAF_ADDR_FILT, 32'h0,
          {16'h0, f_std_id, 1'b0, f_sel, 1'b0, f_ext_id}, 1'b0);
      for (int k = 0; k < 6; k++)
      begin
        r = xs();
        send(r[0],
             f_std_id ^ ((k % 2) ? 11'h001 << (r[4:1] % 11) : 11'h000),
             f_ext_id ^ ((k % 4) > 1 ? r[6:5] : 2'h0));
      end
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
    end
    apb(1'b0, `CAF_ADDR_STAT, 32'h0,
        {16'h0, n_acc[7:0], 7'h00, last_hit}, 1'b0);
    repeat (3) @(posedge clk);
    wrap_up();
  end

  initial
  begin : watchdog
    #200000;
    mismatches++;
    wrap_up();
  end
endmodule : test_can_acceptance_filter_id_match
`default_nettype wire
